// ### evtrc_defs.vh
`ifndef EVTRC_DEFS_VH
`define EVTRC_DEFS_VH

// number of implemented events
`define EVTRC_NUM_EVT 8

// byte offsets of the registers
`define EVTRC_OFS_CFG 9'h000
`define EVTRC_OFS_CTRL 9'h004
`define EVTRC_OFS_HALT 9'h00C
`define EVTRC_OFS_STOP 9'h010
`define EVTRC_OFS_START 9'h014
`define EVTRC_OFS_COUNT 9'h040
`define EVTRC_OFS_STATE 9'h044
// per event: state enable mask at base+8n, control at base+8n+4
`define EVTRC_OFS_EVT_BASE 9'h100
`define EVTRC_OFS_EVT_LAST 9'h13C

// field positions
`define EVTRC_CFG_MERGE 0
`define EVTRC_CTRL_STOP_L 1
`define EVTRC_CTRL_HALT_L 2
`define EVTRC_CTRL_STOP_H 17
`define EVTRC_CTRL_HALT_H 18
`define EVTRC_EVC_HSEL 4
`define EVTRC_EVC_LDSEL 14
`define EVTRC_EVC_SVAL_LSB 15
`define EVTRC_HIGH_LSB 16

// reset values
`define EVTRC_RST_HALT 1'b1
`define EVTRC_RST_STOP 1'b0
`define EVTRC_RST_MASK 8'h00
`define EVTRC_RST_COUNT 32'h0000_0000
`define EVTRC_RST_STATE 5'h00
`define EVTRC_RST_SMASK 32'h0000_0000

// avalon response codes
`define EVTRC_RESP_OKAY 2'h0
`define EVTRC_RESP_SLVERR 2'h2
`define EVTRC_RESP_DECERR 2'h3

`endif

// ### evtrc_top.v
// Operation
// R01: a selected halt event stops its counter and blocks all its further events
// R02: halt mask bit n sets low halt flag, bit 16+n sets high halt flag
// R03: halt flag is cleared only by software, never by an event
// R04: a stop event freezes the count yet events stay enabled
// R05: stop mask bit n sets low stop flag, bit 16+n the high one
// R06: a start event clears the stop flag; counting resumes from held value
// R07: start mask bit n clears low stop flag, bit 16+n the high one
// R08: start events leave the halt flag untouched
// R09: halves are accessible separately; merged mode uses only low mask fields
// R10: merge bit set runs one 32-bit counter over both halves
// R11: merge bit clear runs two independent 16-bit counters
// R12: counter writes need halt set, else bus error; reads always allowed
// R13: count register maps low and high counters or merged halves
// R14: software writes a state variable only while its counter halts
// R15: two 5-bit state variables at 4:0 and 20:16, reset zero
// R16: an event occurs only when enabled for the current state
// R17: an occurring event loads or adds to its state variable
// R18: reset sets both halt flags; a set halt forces stop to zero
// R19: mask bits beyond implemented events do nothing and read zero
`timescale 1ns/1ps
`include "evtrc_defs.vh"

module evtrc_top (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire [8:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg [1:0] avs_response_o,
    output reg avs_waitrequest_o,
    input wire [`EVTRC_NUM_EVT-1:0] evt_trig_i,
    output reg [`EVTRC_NUM_EVT-1:0] evt_occur_o,
    output wire halt_low_o,
    output wire halt_high_o,
    output wire stop_low_o,
    output wire stop_high_o,
    output wire merge_counters_o,
    output wire [31:0] counter_value_o
);

    localparam NE = `EVTRC_NUM_EVT;

    // byte-lane merge of a write into an old value
    function [31:0] evtrc_wmerge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] be;
        integer b;
        begin
            evtrc_wmerge = old_v;
            for (b = 0; b < 4; b = b + 1)
                if (be[b])
                    evtrc_wmerge[b*8 +: 8] = new_v[b*8 +: 8];
        end
    endfunction

    // new state from the events of one counter, highest event wins
    function [4:0] evtrc_nxt_state;
        input [4:0] cur;
        input [NE-1:0] occ;
        input [NE-1:0] ldsel;
        input [5*NE-1:0] sval;
        integer k;
        begin
            evtrc_nxt_state = cur;
            for (k = 0; k < NE; k = k + 1)
                if (occ[k])
                    evtrc_nxt_state = ldsel[k] ? sval[k*5 +: 5] :
                        cur + sval[k*5 +: 5];
        end
    endfunction

    reg merge_ff;
    reg halt_l_ff, halt_h_ff, stop_l_ff, stop_h_ff;
    reg [NE-1:0] hmask_l_ff, hmask_h_ff;
    reg [NE-1:0] smask_l_ff, smask_h_ff;
    reg [NE-1:0] gmask_l_ff, gmask_h_ff;
    reg [31:0] count_ff;
    reg [4:0] state_l_ff, state_h_ff;
    reg [31:0] ev_smask_ff [0:NE-1];
    reg [NE-1:0] ev_hsel_ff, ev_ldsel_ff;
    reg [5*NE-1:0] ev_sval_ff;

    reg nxt_merge, nxt_halt_l, nxt_halt_h, nxt_stop_l, nxt_stop_h;
    reg [NE-1:0] nxt_hmask_l, nxt_hmask_h, nxt_smask_l, nxt_smask_h;
    reg [NE-1:0] nxt_gmask_l, nxt_gmask_h;
    reg [31:0] nxt_count;
    reg [4:0] nxt_state_l, nxt_state_h;
    reg [31:0] nxt_rdata;
    reg [1:0] nxt_resp;

    reg [NE-1:0] ev_occ, hi_sel;
    reg halt_ev_l, halt_ev_h, stop_ev_l, stop_ev_h, start_ev_l, start_ev_h;
    reg run_l, run_h;
    reg req, wr_ok, hit_evt, hit_evc;
    reg [2:0] evt_idx;
    reg [31:0] wv, ctrl_rd, mask_rd_h, mask_rd_s, mask_rd_g;
    reg [31:0] cnt_rd, st_rd;
    integer n;
    integer m;

    // event qualification by counter, state and halt
    always @*
    begin
        ev_occ = {NE{1'b0}};
        hi_sel = {NE{1'b0}};
        for (n = 0; n < NE; n = n + 1)
        begin
            hi_sel[n] = ~merge_ff & ev_hsel_ff[n];
            if (hi_sel[n])
                ev_occ[n] = evt_trig_i[n] & ev_smask_ff[n][state_h_ff]
                    & ~halt_h_ff; // [R16] [R01]
            else
                ev_occ[n] = evt_trig_i[n] & ev_smask_ff[n][state_l_ff]
                    & ~halt_l_ff; // [R16] [R01]
        end
    end

    // mask decode into per-counter actions
    always @*
    begin
        halt_ev_l = |(ev_occ & hmask_l_ff); // [R02]
        halt_ev_h = ~merge_ff & |(ev_occ & hmask_h_ff); // [R02] [R09]
        stop_ev_l = |(ev_occ & smask_l_ff); // [R05]
        stop_ev_h = ~merge_ff & |(ev_occ & smask_h_ff); // [R05] [R09]
        start_ev_l = |(ev_occ & gmask_l_ff); // [R07]
        start_ev_h = ~merge_ff & |(ev_occ & gmask_h_ff); // [R07] [R09]
        // no increment in the cycle a halt or stop event lands
        run_l = ~halt_l_ff & ~stop_l_ff & ~halt_ev_l & ~stop_ev_l; // [R04]
        run_h = ~halt_h_ff & ~stop_h_ff & ~halt_ev_h & ~stop_ev_h; // [R04]
    end

    // readback views of the registers
    always @*
    begin
        ctrl_rd = 32'h0000_0000;
        ctrl_rd[`EVTRC_CTRL_HALT_L] = halt_l_ff;
        ctrl_rd[`EVTRC_CTRL_STOP_L] = stop_l_ff;
        ctrl_rd[`EVTRC_CTRL_HALT_H] = halt_h_ff;
        ctrl_rd[`EVTRC_CTRL_STOP_H] = stop_h_ff;
        mask_rd_h = 32'h0000_0000;
        mask_rd_s = 32'h0000_0000;
        mask_rd_g = 32'h0000_0000;
        mask_rd_h[NE-1:0] = hmask_l_ff; // [R19]
        mask_rd_h[`EVTRC_HIGH_LSB +: NE] = hmask_h_ff;
        mask_rd_s[NE-1:0] = smask_l_ff;
        mask_rd_s[`EVTRC_HIGH_LSB +: NE] = smask_h_ff;
        mask_rd_g[NE-1:0] = gmask_l_ff;
        mask_rd_g[`EVTRC_HIGH_LSB +: NE] = gmask_h_ff;
        cnt_rd = count_ff; // [R13]
        st_rd = 32'h0000_0000; // [R15]
        st_rd[4:0] = state_l_ff;
        st_rd[`EVTRC_HIGH_LSB +: 5] = state_h_ff;
    end

    // bus decode, read mux and error answer
    always @*
    begin
        req = (avs_read_i | avs_write_i) & avs_waitrequest_o;
        evt_idx = avs_address_i[5:3];
        hit_evt = (avs_address_i >= `EVTRC_OFS_EVT_BASE) &&
            (avs_address_i <= `EVTRC_OFS_EVT_LAST) &&
            (avs_address_i[1:0] == 2'h0);
        hit_evc = hit_evt & avs_address_i[2];
        nxt_rdata = 32'h0000_0000;
        nxt_resp = `EVTRC_RESP_OKAY;
        case (avs_address_i)
            `EVTRC_OFS_CFG: nxt_rdata[`EVTRC_CFG_MERGE] = merge_ff;
            `EVTRC_OFS_CTRL: nxt_rdata = ctrl_rd;
            `EVTRC_OFS_HALT: nxt_rdata = mask_rd_h;
            `EVTRC_OFS_STOP: nxt_rdata = mask_rd_s;
            `EVTRC_OFS_START: nxt_rdata = mask_rd_g;
            `EVTRC_OFS_COUNT:
            begin
                nxt_rdata = cnt_rd;
                // writes to a running half are refused
                if (avs_write_i && ((|avs_byteenable_i[1:0] && !halt_l_ff)
                    || (|avs_byteenable_i[3:2] &&
                    !(merge_ff ? halt_l_ff : halt_h_ff))))
                    nxt_resp = `EVTRC_RESP_SLVERR; // [R12]
            end
            `EVTRC_OFS_STATE: nxt_rdata = st_rd;
            default:
            begin
                if (hit_evc)
                begin
                    nxt_rdata[`EVTRC_EVC_HSEL] = ev_hsel_ff[evt_idx];
                    nxt_rdata[`EVTRC_EVC_LDSEL] = ev_ldsel_ff[evt_idx];
                    nxt_rdata[`EVTRC_EVC_SVAL_LSB +: 5] =
                        ev_sval_ff[evt_idx*5 +: 5];
                end
                else if (hit_evt)
                    nxt_rdata = ev_smask_ff[evt_idx];
                else
                    nxt_resp = `EVTRC_RESP_DECERR;
            end
        endcase
        if (avs_write_i)
            nxt_rdata = 32'h0000_0000;
        wr_ok = req & avs_write_i & (nxt_resp == `EVTRC_RESP_OKAY);
    end

    // next values of configuration, masks and flags
    always @*
    begin
        nxt_merge = merge_ff;
        nxt_hmask_l = hmask_l_ff;
        nxt_hmask_h = hmask_h_ff;
        nxt_smask_l = smask_l_ff;
        nxt_smask_h = smask_h_ff;
        nxt_gmask_l = gmask_l_ff;
        nxt_gmask_h = gmask_h_ff;
        nxt_halt_l = halt_l_ff;
        nxt_halt_h = halt_h_ff;
        nxt_stop_l = stop_l_ff;
        nxt_stop_h = stop_h_ff;
        wv = 32'h0000_0000;
        if (wr_ok)
        begin
            case (avs_address_i)
                `EVTRC_OFS_CFG:
                begin
                    wv = evtrc_wmerge({31'h0000_0000, merge_ff},
                        avs_writedata_i, avs_byteenable_i);
                    nxt_merge = wv[`EVTRC_CFG_MERGE];
                end
                `EVTRC_OFS_CTRL:
                begin
                    // software alone may drop a halt
                    wv = evtrc_wmerge(ctrl_rd, avs_writedata_i,
                        avs_byteenable_i);
                    nxt_halt_l = wv[`EVTRC_CTRL_HALT_L]; // [R03]
                    nxt_halt_h = wv[`EVTRC_CTRL_HALT_H]; // [R03]
                    nxt_stop_l = wv[`EVTRC_CTRL_STOP_L];
                    nxt_stop_h = wv[`EVTRC_CTRL_STOP_H];
                end
                `EVTRC_OFS_HALT:
                begin
                    wv = evtrc_wmerge(mask_rd_h, avs_writedata_i,
                        avs_byteenable_i); // [R09]
                    nxt_hmask_l = wv[NE-1:0];
                    nxt_hmask_h = wv[`EVTRC_HIGH_LSB +: NE];
                end
                `EVTRC_OFS_STOP:
                begin
                    wv = evtrc_wmerge(mask_rd_s, avs_writedata_i,
                        avs_byteenable_i); // [R09]
                    nxt_smask_l = wv[NE-1:0];
                    nxt_smask_h = wv[`EVTRC_HIGH_LSB +: NE];
                end
                `EVTRC_OFS_START:
                begin
                    wv = evtrc_wmerge(mask_rd_g, avs_writedata_i,
                        avs_byteenable_i); // [R09]
                    nxt_gmask_l = wv[NE-1:0];
                    nxt_gmask_h = wv[`EVTRC_HIGH_LSB +: NE];
                end
                default: wv = 32'h0000_0000;
            endcase
        end
        // hardware set beats software clear on halt; start never touches it
        nxt_halt_l = nxt_halt_l | halt_ev_l; // [R01] [R08]
        nxt_halt_h = nxt_halt_h | halt_ev_h; // [R01] [R08]
        // stop: halt forces zero, stop event wins over start
        if (nxt_halt_l)
            nxt_stop_l = 1'b0; // [R18]
        else if (stop_ev_l)
            nxt_stop_l = 1'b1; // [R04]
        else if (start_ev_l)
            nxt_stop_l = 1'b0; // [R06]
        if (nxt_halt_h)
            nxt_stop_h = 1'b0; // [R18]
        else if (stop_ev_h)
            nxt_stop_h = 1'b1; // [R04]
        else if (start_ev_h)
            nxt_stop_h = 1'b0; // [R06]
    end

    // counter and state variable updates
    always @*
    begin
        nxt_count = count_ff;
        if (merge_ff)
        begin
            if (run_l)
                nxt_count = count_ff + 32'h0000_0001; // [R10]
        end
        else
        begin
            if (run_l)
                nxt_count[15:0] = count_ff[15:0] + 16'h0001; // [R11]
            if (run_h)
                nxt_count[31:16] = count_ff[31:16] + 16'h0001; // [R11]
        end
        if (wr_ok && avs_address_i == `EVTRC_OFS_COUNT)
            nxt_count = evtrc_wmerge(count_ff, avs_writedata_i,
                avs_byteenable_i); // [R12] [R13]
        nxt_state_l = evtrc_nxt_state(state_l_ff, ev_occ & ~hi_sel,
            ev_ldsel_ff, ev_sval_ff); // [R17]
        nxt_state_h = evtrc_nxt_state(state_h_ff, ev_occ & hi_sel,
            ev_ldsel_ff, ev_sval_ff); // [R17]
        if (wr_ok && avs_address_i == `EVTRC_OFS_STATE)
        begin
            // a running counter's state is kept
            if (avs_byteenable_i[0] && halt_l_ff)
                nxt_state_l = avs_writedata_i[4:0]; // [R14]
            if (avs_byteenable_i[2] && !merge_ff && halt_h_ff)
                nxt_state_h = avs_writedata_i[20:16]; // [R14] [R09]
        end
    end

    // main registers
    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            merge_ff <= 1'b0;
            halt_l_ff <= `EVTRC_RST_HALT; // [R18]
            halt_h_ff <= `EVTRC_RST_HALT; // [R18]
            stop_l_ff <= `EVTRC_RST_STOP;
            stop_h_ff <= `EVTRC_RST_STOP;
            hmask_l_ff <= `EVTRC_RST_MASK;
            hmask_h_ff <= `EVTRC_RST_MASK;
            smask_l_ff <= `EVTRC_RST_MASK;
            smask_h_ff <= `EVTRC_RST_MASK;
            gmask_l_ff <= `EVTRC_RST_MASK;
            gmask_h_ff <= `EVTRC_RST_MASK;
            count_ff <= `EVTRC_RST_COUNT;
            state_l_ff <= `EVTRC_RST_STATE; // [R15]
            state_h_ff <= `EVTRC_RST_STATE; // [R15]
            evt_occur_o <= {NE{1'b0}};
        end
        else
        begin
            merge_ff <= nxt_merge;
            halt_l_ff <= nxt_halt_l;
            halt_h_ff <= nxt_halt_h;
            stop_l_ff <= nxt_stop_l;
            stop_h_ff <= nxt_stop_h;
            hmask_l_ff <= nxt_hmask_l;
            hmask_h_ff <= nxt_hmask_h;
            smask_l_ff <= nxt_smask_l;
            smask_h_ff <= nxt_smask_h;
            gmask_l_ff <= nxt_gmask_l;
            gmask_h_ff <= nxt_gmask_h;
            count_ff <= nxt_count;
            state_l_ff <= nxt_state_l;
            state_h_ff <= nxt_state_h;
            evt_occur_o <= ev_occ;
        end
    end

    // per-event state enables and state actions
    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            for (m = 0; m < NE; m = m + 1)
                ev_smask_ff[m] <= `EVTRC_RST_SMASK;
            ev_hsel_ff <= {NE{1'b0}};
            ev_ldsel_ff <= {NE{1'b0}};
            ev_sval_ff <= {5*NE{1'b0}};
        end
        else if (wr_ok && hit_evc)
        begin
            if (avs_byteenable_i[0])
                ev_hsel_ff[evt_idx] <= avs_writedata_i[`EVTRC_EVC_HSEL];
            if (avs_byteenable_i[1])
                ev_ldsel_ff[evt_idx] <= avs_writedata_i[`EVTRC_EVC_LDSEL];
            if (avs_byteenable_i[1] && avs_byteenable_i[2])
                ev_sval_ff[evt_idx*5 +: 5] <=
                    avs_writedata_i[`EVTRC_EVC_SVAL_LSB +: 5];
        end
        else if (wr_ok && hit_evt)
            ev_smask_ff[evt_idx] <= evtrc_wmerge(ev_smask_ff[evt_idx],
                avs_writedata_i, avs_byteenable_i);
    end

    // bus answer: one wait cycle, then one cycle of waitrequest low
    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
            avs_response_o <= `EVTRC_RESP_OKAY;
        end
        else if (req)
        begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= nxt_rdata;
            avs_response_o <= nxt_resp;
        end
        else
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
            avs_response_o <= `EVTRC_RESP_OKAY;
        end
    end

    assign halt_low_o = halt_l_ff;
    assign halt_high_o = halt_h_ff;
    assign stop_low_o = stop_l_ff;
    assign stop_high_o = stop_h_ff;
    assign merge_counters_o = merge_ff;
    assign counter_value_o = count_ff;

endmodule // evtrc_top

// ### evtrc_top_asserts.sv
`timescale 1ns/1ps
`include "evtrc_defs.vh"

module evtrc_top_asserts (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire [8:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [3:0] avs_byteenable_i,
    input wire [1:0] avs_response_o,
    input wire avs_waitrequest_o,
    input wire [`EVTRC_NUM_EVT-1:0] evt_occur_o,
    input wire halt_low_o,
    input wire halt_high_o,
    input wire stop_low_o,
    input wire merge_counters_o,
    input wire [31:0] counter_value_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    // low counter neither halted nor stopped
    sequence s_lo_free;
        !halt_low_o && !stop_low_o;
    endsequence
    // bus write taken at a given address
    sequence s_wr_taken(adr);
        avs_write_i && avs_waitrequest_o && avs_address_i == adr;
    endsequence

    // checks on counting, freezing and bus answers
    a_low_counts: assert property (
        (s_lo_free ##0 (!merge_counters_o && !avs_write_i)) ##1 s_lo_free
        |-> counter_value_o[15:0] == $past(counter_value_o[15:0]) + 16'h0001)
        else $error("low counter did not step by one");
    a_merged_counts: assert property (
        (s_lo_free ##0 (merge_counters_o && !avs_write_i)) ##1 s_lo_free
        |-> counter_value_o == $past(counter_value_o) + 32'h0000_0001)
        else $error("merged counter did not step by one");
    a_stop_holds: assert property (
        stop_low_o && !merge_counters_o && !avs_write_i
        |=> $stable(counter_value_o[15:0]))
        else $error("stopped low counter moved");
    a_halt_frozen: assert property (
        halt_low_o && halt_high_o && !avs_write_i
        |=> $stable(counter_value_o))
        else $error("halted counters moved");
    a_halt_quiet: assert property (
        halt_low_o && halt_high_o |=> evt_occur_o == 8'h00)
        else $error("event occurred while halted");
    a_halt_sticky: assert property (
        halt_low_o && !(avs_write_i && avs_waitrequest_o
        && avs_address_i == `EVTRC_OFS_CTRL) |=> halt_low_o)
        else $error("halt flag cleared without software");
    a_halt_clr_stop: assert property (
        halt_low_o |-> !stop_low_o)
        else $error("stop flag set while halted");
    a_cnt_wr_err: assert property (
        s_wr_taken(`EVTRC_OFS_COUNT) ##0 (!halt_low_o
        && avs_byteenable_i == 4'hF) |=> !avs_waitrequest_o
        && avs_response_o == `EVTRC_RESP_SLVERR)
        else $error("counter write while running not refused");
    a_bus_answer: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not one cycle later");
endmodule // evtrc_top_asserts

bind evtrc_top evtrc_top_asserts u_chk (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_response_o(avs_response_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .evt_occur_o(evt_occur_o),
    .halt_low_o(halt_low_o),
    .halt_high_o(halt_high_o),
    .stop_low_o(stop_low_o),
    .merge_counters_o(merge_counters_o),
    .counter_value_o(counter_value_o)
);

// ### evtrc_top_tb.sv
`timescale 1ns/1ps
`include "evtrc_defs.vh"

module evtrc_top_tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [8:0] adr = 9'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] ben = 4'hF;
    logic [7:0] trig = 8'h00;
    wire [31:0] rdat;
    wire [1:0] resp;
    wire wait_req;
    wire [7:0] occ;
    wire halt_lo;
    wire halt_hi;
    wire stop_lo;
    wire stop_hi;
    wire merge;
    wire [31:0] cnt;
    logic [31:0] q;
    logic [31:0] h;
    logic [1:0] r;
    logic [7:0] o;
    logic [8:0] offs [0:4] = '{`EVTRC_OFS_HALT, `EVTRC_OFS_STOP,
        `EVTRC_OFS_START, `EVTRC_OFS_COUNT, `EVTRC_OFS_STATE};
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    int i;

    evtrc_top uut (
        .core_clk_i(core_clk),
        .sys_rst_i(sys_rst),
        .avs_address_i(adr),
        .avs_read_i(rd),
        .avs_write_i(wr),
        .avs_writedata_i(wdat),
        .avs_byteenable_i(ben),
        .avs_readdata_o(rdat),
        .avs_response_o(resp),
        .avs_waitrequest_o(wait_req),
        .evt_trig_i(trig),
        .evt_occur_o(occ),
        .halt_low_o(halt_lo),
        .halt_high_o(halt_hi),
        .stop_low_o(stop_lo),
        .stop_high_o(stop_hi),
        .merge_counters_o(merge),
        .counter_value_o(cnt)
    );

    // 10 MHz clock
    always #50 core_clk = ~core_clk;

    // compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // counts and verdict
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // one avalon transfer, held until waitrequest seen low
    task bus(input logic w, input logic [8:0] a, input logic [31:0] d,
        input logic [3:0] be);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        ben <= be;
        @(posedge core_clk);
        while (wait_req !== 1'b0)
            @(posedge core_clk);
        q = rdat;
        r = resp;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge core_clk);
    endtask

    // one-cycle trigger, occurrence taken a cycle later
    task pulse(input int n);
        trig[n] <= 1'b1;
        @(posedge core_clk);
        trig <= 8'h00;
        @(posedge core_clk);
        o = occ;
    endtask

    // hang guard
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_mismatch++;
            end_sim;
        end
    end

    // main sequence
    initial
    begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        check({halt_hi, halt_lo, stop_hi, stop_lo}, 4'hC);
        for (i = 0; i < 5; i++)
        begin
            bus(1'b0, offs[i], 32'h0000_0000, 4'hF);
            check(q, 32'h0000_0000);
        end
        $display("test reset done");
        for (i = 0; i < 3; i++)
        begin
            bus(1'b1, offs[i], 32'hFFFF_FFFF, 4'hF);
            bus(1'b0, offs[i], 32'h0000_0000, 4'hF);
            check(q, 32'h00FF_00FF);
            bus(1'b1, offs[i], 32'h0000_0000, 4'hC);
            bus(1'b0, offs[i], 32'h0000_0000, 4'hF);
            check(q, 32'h0000_00FF);
            bus(1'b1, offs[i], 32'h0000_0000, 4'hF);
        end
        $display("test masks done");
        bus(1'b1, `EVTRC_OFS_COUNT, 32'h0002_0010, 4'hF);
        check(r, `EVTRC_RESP_OKAY);
        bus(1'b1, `EVTRC_OFS_COUNT, 32'hFFFF_0007, 4'h3);
        bus(1'b0, `EVTRC_OFS_COUNT, 32'h0000_0000, 4'hF);
        check(q, 32'h0002_0007);
        check(cnt, 32'h0002_0007);
        bus(1'b1, `EVTRC_OFS_STATE, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, `EVTRC_OFS_STATE, 32'h0000_0000, 4'hF);
        check(q, 32'h001F_001F);
        bus(1'b1, `EVTRC_OFS_STATE, 32'h0000_0000, 4'hF);
        bus(1'b0, 9'h080, 32'h0000_0000, 4'hF);
        check(r, `EVTRC_RESP_DECERR);
        $display("test access done");
        // event 0 only in state 0, events 1 to 4 in states 0 and 5
        for (i = 0; i < 5; i++)
            bus(1'b1, `EVTRC_OFS_EVT_BASE + 9'(8 * i),
                (i == 0) ? 32'h0000_0001 : 32'h0000_0021, 4'hF);
        bus(1'b1, 9'h114, 32'h0000_0010, 4'hF);
        bus(1'b1, 9'h124, 32'h0002_C000, 4'hF);
        bus(1'b1, `EVTRC_OFS_HALT, 32'h0000_0008, 4'hF);
        bus(1'b1, `EVTRC_OFS_STOP, 32'h0004_0001, 4'hF);
        bus(1'b1, `EVTRC_OFS_START, 32'h0002_0002, 4'hF);
        bus(1'b1, `EVTRC_OFS_CTRL, 32'h0000_0000, 4'hF);
        bus(1'b1, `EVTRC_OFS_COUNT, 32'h0000_0000, 4'hF);
        check(r, `EVTRC_RESP_SLVERR);
        pulse(0);
        check(o, 8'h01);
        check({stop_hi, stop_lo}, 2'h1);
        bus(1'b0, `EVTRC_OFS_COUNT, 32'h0000_0000, 4'hF);
        h = q;
        bus(1'b0, `EVTRC_OFS_COUNT, 32'h0000_0000, 4'hF);
        check(q[15:0], h[15:0]);
        pulse(2);
        check({stop_hi, stop_lo}, 2'h3);
        pulse(1);
        check({stop_hi, stop_lo}, 2'h0);
        bus(1'b0, `EVTRC_OFS_COUNT, 32'h0000_0000, 4'hF);
        check(q[15:0] - h[15:0] < 16'h0020, 1'h1);
        check(r, `EVTRC_RESP_OKAY);
        $display("test stop done");
        pulse(4);
        check(o, 8'h10);
        bus(1'b0, `EVTRC_OFS_STATE, 32'h0000_0000, 4'hF);
        check(q, 32'h0000_0005);
        pulse(0);
        check(o, 8'h00);
        check(stop_lo, 1'h0);
        pulse(3);
        check({halt_hi, halt_lo}, 2'h1);
        pulse(1);
        check(o, 8'h00);
        check(halt_lo, 1'h1);
        // high-counter event in the low start mask leaves the low halt set and low stop clear
        bus(1'b1, `EVTRC_OFS_START, 32'h0002_0006, 4'hF);
        pulse(2);
        check(o, 8'h04);
        check({halt_lo, stop_lo}, 2'h2);
        $display("test halt done");
        bus(1'b1, `EVTRC_OFS_CTRL, 32'h0004_0004, 4'hF);
        bus(1'b1, `EVTRC_OFS_CFG, 32'h0000_0001, 4'hF);
        check(merge, 1'h1);
        bus(1'b1, `EVTRC_OFS_COUNT, 32'h0000_FFF0, 4'hF);
        check(r, `EVTRC_RESP_OKAY);
        bus(1'b1, `EVTRC_OFS_CTRL, 32'h0000_0000, 4'hF);
        repeat (40) @(posedge core_clk);
        bus(1'b0, `EVTRC_OFS_COUNT, 32'h0000_0000, 4'hF);
        check(q[31:16], 16'h0001);
        $display("test merge done");
        end_sim;
    end
endmodule // evtrc_top_tb
